// >>> verilog/ftf_pkg.sv
// Package for the fall-through FIFO host controller: pin bundles and timing counts
package ftf_pkg;
    // Word width of the device and its total depth
    localparam int unsigned FTF_DATA_W = 4;
    localparam int unsigned FTF_DEPTH = 64;
    localparam int unsigned FTF_STACK_DEPTH = 62;

    // Clock period and device timing, all in picoseconds
    localparam int unsigned FTF_CLK_PERIOD_PS = 25000;
    localparam int unsigned FTF_THROUGHPUT_PS = 1000000;
    localparam int unsigned FTF_MCLR_LOW_PS = 10000;
    localparam int unsigned FTF_MCLR_REC_PS = 35000;

    // Least times round up to whole cycles
    localparam int unsigned FTF_THRU_CYC =
        (FTF_THROUGHPUT_PS + FTF_CLK_PERIOD_PS - 1) / FTF_CLK_PERIOD_PS;
    localparam int unsigned FTF_MCLR_CYC =
        (FTF_MCLR_LOW_PS + FTF_CLK_PERIOD_PS - 1) / FTF_CLK_PERIOD_PS;
    localparam int unsigned FTF_REC_CYC =
        (FTF_MCLR_REC_PS + FTF_CLK_PERIOD_PS - 1) / FTF_CLK_PERIOD_PS;

    // Counter width covering every count above
    localparam int unsigned FTF_CNT_W = 7;

    // Reset values of the pin drivers
    localparam logic FTF_PUSH_RST = 1'b0;
    localparam logic FTF_POP_RST = 1'b0;
    localparam logic FTF_MCLR_N_RST = 1'b0;

    // Pins the controller drives into the device
    typedef struct packed {
        logic [FTF_DATA_W-1:0] din;
        logic push;
        logic pop;
        logic master_clear_n;
    } ftf_drive_s;

    // Pins the device drives back
    typedef struct packed {
        logic [FTF_DATA_W-1:0] dout;
        logic space_available;
        logic data_valid;
    } ftf_sense_s;

    // Write-side sequencer states
    typedef enum logic [1:0] {
        FTF_W_IDLE = 2'b00,
        FTF_W_SETUP = 2'b01,
        FTF_W_HIGH = 2'b10,
        FTF_W_LOW = 2'b11
    } ftf_wr_state_e;

    // Read-side sequencer states
    typedef enum logic [1:0] {
        FTF_R_IDLE = 2'b00,
        FTF_R_SETTLE = 2'b01,
        FTF_R_HIGH = 2'b10
    } ftf_rd_state_e;
endpackage : ftf_pkg

// >>> verilog/ftf_sync.sv
// Two-stage synchroniser for the device's asynchronous outputs
`timescale 1ns/1ps
module ftf_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Asynchronous input and its synchronised copy
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // Refuse an empty bundle while elaborating
    if (WIDTH < 1)
    begin : g_bad_width
        $error("ftf_sync: WIDTH must be at least 1");
    end

    // First stage is read only by the second
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : ftf_sync

// >>> verilog/ftf_host.sv
// Host controller that drives a 64x4 fall-through FIFO device through its pins
`timescale 1ns/1ps
//
// Overview of operation
// - Host raises push only while space_available is high.
// - Host raises pop only while data_valid is high.
// - Flag low for the throughput time means full or empty.
// - Master clear is active low, held at least 10 ns, raises space_available.
module ftf_host #(
    parameter int unsigned DATA_W = ftf_pkg::FTF_DATA_W,
    parameter int unsigned THRU_CYC = ftf_pkg::FTF_THRU_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Producer side: words to write into the device
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [DATA_W-1:0] wr_data,
    // Consumer side: words read back from the device
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [DATA_W-1:0] rd_data,
    // Control and status
    input wire logic clear_req,
    output logic fifo_full,
    output logic fifo_empty,
    // Device pins
    output ftf_pkg::ftf_drive_s dev_drive,
    input wire ftf_pkg::ftf_sense_s dev_sense
);
    import ftf_pkg::*;

    localparam int unsigned SYNC_W = $bits(ftf_sense_s);

    ftf_sense_s sense_s;
    ftf_wr_state_e wr_state_q;
    ftf_rd_state_e rd_state_q;
    logic [DATA_W-1:0] din_q;
    logic push_q;
    logic pop_q;
    logic mclr_n_q;
    logic [FTF_CNT_W-1:0] clr_cnt_q;
    logic clr_busy;
    logic [FTF_CNT_W-1:0] full_cnt_q;
    logic [FTF_CNT_W-1:0] empty_cnt_q;
    logic rd_valid_q;
    logic [DATA_W-1:0] rd_data_q;

    // Refuse values the logic cannot serve; a count within the three-cycle
    // sense lag would flag full or empty in the middle of a normal shift
    if (DATA_W != FTF_DATA_W)
    begin : g_bad_width
        $error("ftf_host: DATA_W must match the device word width");
    end
    if (THRU_CYC < 4 || THRU_CYC >= (1 << FTF_CNT_W))
    begin : g_bad_thru
        $error("ftf_host: THRU_CYC out of counter range");
    end

    // Device outputs are asynchronous to clk, so all pass two flops
    ftf_sync #(
        .WIDTH(SYNC_W)
    ) u_sense_sync (
        .clk(clk),
        .nrst(nrst),
        .async_in(dev_sense),
        .sync_out(sense_s)
    );

    // Clear pulse: low for the minimum width, then recovery before any push
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mclr_n_q <= FTF_MCLR_N_RST;
            clr_cnt_q <= FTF_CNT_W'(FTF_MCLR_CYC + FTF_REC_CYC);
        end
        else if (clear_req)
        begin
            mclr_n_q <= 1'b0;
            clr_cnt_q <= FTF_CNT_W'(FTF_MCLR_CYC + FTF_REC_CYC);
        end
        else if (clr_cnt_q != '0)
        begin
            clr_cnt_q <= clr_cnt_q - 1'b1;
            // Release once the low time has been met, recovery keeps counting
            if (clr_cnt_q <= FTF_CNT_W'(FTF_REC_CYC + 1))
            begin
                mclr_n_q <= 1'b1;
            end
        end
    end

    assign clr_busy = (clr_cnt_q != '0) || clear_req;

    // Write sequencer: setup data, push high until acknowledged, then drop
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_state_q <= FTF_W_IDLE;
            push_q <= FTF_PUSH_RST;
            din_q <= '0;
        end
        else if (clr_busy)
        begin
            wr_state_q <= FTF_W_IDLE;
            push_q <= 1'b0;
        end
        else
        begin
            unique case (wr_state_q)
                FTF_W_IDLE:
                begin
                    // Only start while the first cell is free
                    if (wr_valid && sense_s.space_available)
                    begin
                        din_q <= wr_data;
                        wr_state_q <= FTF_W_SETUP;
                    end
                end
                FTF_W_SETUP:
                begin
                    // Data stood a full cycle, ahead of the 1 ns setup
                    push_q <= 1'b1;
                    wr_state_q <= FTF_W_HIGH;
                end
                FTF_W_HIGH:
                begin
                    // Hold push until the device drops its ready flag
                    if (!sense_s.space_available)
                    begin
                        push_q <= 1'b0;
                        wr_state_q <= FTF_W_LOW;
                    end
                end
                FTF_W_LOW:
                begin
                    // Din stays put one more cycle to cover hold time
                    wr_state_q <= FTF_W_IDLE;
                end
            endcase
        end
    end

    // Word accepted from the producer in the idle cycle, while space_available is high
    assign wr_ready = (wr_state_q == FTF_W_IDLE) && !clr_busy && sense_s.space_available;

    // Read sequencer: only pops when the holding slot is free
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_state_q <= FTF_R_IDLE;
            pop_q <= FTF_POP_RST;
        end
        else if (clr_busy)
        begin
            rd_state_q <= FTF_R_IDLE;
            pop_q <= 1'b0;
        end
        else
        begin
            unique case (rd_state_q)
                FTF_R_IDLE:
                begin
                    // One cycle of settle lets dout sync catch up with the flag
                    if (sense_s.data_valid && !rd_valid_q)
                    begin
                        rd_state_q <= FTF_R_SETTLE;
                    end
                end
                FTF_R_SETTLE:
                begin
                    pop_q <= 1'b1;
                    rd_state_q <= FTF_R_HIGH;
                end
                FTF_R_HIGH:
                begin
                    if (!sense_s.data_valid)
                    begin
                        pop_q <= 1'b0;
                        rd_state_q <= FTF_R_IDLE;
                    end
                end
                default:
                begin
                    rd_state_q <= FTF_R_IDLE;
                    pop_q <= 1'b0;
                end
            endcase
        end
    end

    // Holding slot: word captured as pop rises, kept until the consumer takes it or clear_req drops it
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_valid_q <= 1'b0;
            rd_data_q <= '0;
        end
        else if (clear_req)
        begin
            rd_valid_q <= 1'b0;
        end
        else if (rd_state_q == FTF_R_SETTLE && !clr_busy)
        begin
            rd_data_q <= sense_s.dout;
            rd_valid_q <= 1'b1;
        end
        else if (rd_ready)
        begin
            rd_valid_q <= 1'b0;
        end
    end

    // Full and empty: flag low for the throughput time while idle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            full_cnt_q <= '0;
            empty_cnt_q <= '0;
        end
        else
        begin
            if (sense_s.space_available || push_q || clr_busy)
            begin
                full_cnt_q <= '0;
            end
            else if (full_cnt_q != FTF_CNT_W'(THRU_CYC))
            begin
                full_cnt_q <= full_cnt_q + 1'b1;
            end
            if (sense_s.data_valid || pop_q)
            begin
                empty_cnt_q <= '0;
            end
            else if (empty_cnt_q != FTF_CNT_W'(THRU_CYC))
            begin
                empty_cnt_q <= empty_cnt_q + 1'b1;
            end
        end
    end

    assign fifo_full = (full_cnt_q == FTF_CNT_W'(THRU_CYC));
    assign fifo_empty = (empty_cnt_q == FTF_CNT_W'(THRU_CYC)) && !rd_valid_q;

    // Pins and consumer outputs, all from flops; sides are independent
    assign dev_drive.din = din_q;
    assign dev_drive.push = push_q;
    assign dev_drive.pop = pop_q;
    assign dev_drive.master_clear_n = mclr_n_q;
    assign rd_valid = rd_valid_q;
    assign rd_data = rd_data_q;
endmodule : ftf_host

// >>> verification/ftf_host_assertions.sv
// Checker for the fall-through FIFO host controller pins
`timescale 1ns/1ps
module ftf_host_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // User side
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic [ftf_pkg::FTF_DATA_W-1:0] wr_data,
    input wire logic rd_valid,
    input wire logic rd_ready,
    input wire logic [ftf_pkg::FTF_DATA_W-1:0] rd_data,
    input wire logic clear_req,
    // Device pins
    input wire ftf_pkg::ftf_drive_s dev_drive,
    input wire ftf_pkg::ftf_sense_s dev_sense
);
    import ftf_pkg::*;
    // All checks run on the host clock and rest during reset
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    a_push_follows:
    assert property (wr_valid && wr_ready && !clear_req |-> ##[1:2] $rose(dev_drive.push))
        else $error("push late");
    a_din_hold:
    assert property (dev_drive.push |-> $stable(dev_drive.din)) else $error("din moved");
    a_ready_gate:
    assert property (wr_ready |-> !dev_drive.push && dev_drive.master_clear_n)
        else $error("ready while busy");
    a_push_release:
    assert property ($fell(dev_drive.push) && dev_drive.master_clear_n |->
        !$past(dev_sense.space_available) && !$past(dev_sense.space_available, 2))
        else $error("push dropped early");
    a_pop_start:
    assert property ($rose(dev_drive.pop) |-> $rose(rd_valid) && rd_data == dev_sense.dout)
        else $error("pop without word");
    a_pop_release:
    assert property ($fell(dev_drive.pop) && dev_drive.master_clear_n |->
        !$past(dev_sense.data_valid) && !$past(dev_sense.data_valid, 2))
        else $error("pop dropped early");
    a_hold_word:
    assert property (rd_valid && !rd_ready && !clear_req && dev_drive.master_clear_n |=>
        rd_valid && $stable(rd_data)) else $error("word lost");
    a_clear_entry:
    assert property (clear_req |=> !dev_drive.master_clear_n && !dev_drive.push && !dev_drive.pop)
        else $error("clear late");
endmodule : ftf_host_assertions

bind ftf_host ftf_host_assertions u_ftf_host_assertions (.clk(clk), .nrst(nrst),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .clear_req(clear_req),
    .dev_drive(dev_drive), .dev_sense(dev_sense));

// >>> verification/ftf_dev_model.sv
// Behavioural model of the 64x4 fall-through FIFO device
`timescale 1ns/1ps
module ftf_dev_model #(
    parameter int unsigned DEPTH = ftf_pkg::FTF_DEPTH,
    parameter realtime FALL_NS = 100.0
) (
    // Pins from the host
    input wire ftf_pkg::ftf_drive_s drv,
    // Pins back to the host
    output ftf_pkg::ftf_sense_s sns
);
    import ftf_pkg::*;
    logic [FTF_DATA_W-1:0] stack_q[$];
    realtime stamp_q[$];
    logic [FTF_DATA_W-1:0] in_word;
    logic in_full = 1'b0;
    logic out_full = 1'b0;
    logic push_l = 1'b0;
    logic pop_l = 1'b0;
    // Polled off the clock grid so pins never change in a host edge's time step
    initial
    begin
        sns = '0;
        #0.7;
        forever
        begin
            if (!drv.master_clear_n)
            begin
                stack_q.delete();
                stamp_q.delete();
                in_full = 1'b0;
                out_full = 1'b0;
            end
            else
            begin
                if (drv.push && !push_l)
                begin
                    in_word = drv.din;
                    in_full = 1'b1;
                end
                if (!drv.push && in_full)
                begin
                    stack_q.push_back(in_word);
                    stamp_q.push_back($realtime);
                    in_full = 1'b0;
                end
                if (!drv.pop && pop_l)
                    out_full = 1'b0;
                // Only this load writes dout, so it holds when empty
                if (!out_full && !drv.pop && stack_q.size() > 0 &&
                    $realtime - stamp_q[0] >= FALL_NS)
                begin
                    sns.dout = stack_q.pop_front();
                    stamp_q.pop_front();
                    out_full = 1'b1;
                end
            end
            // The 62-deep stack plus both end stages make up the depth
            sns.space_available = !drv.push && (stack_q.size() + int'(in_full) +
                int'(out_full) < int'(DEPTH));
            sns.data_valid = out_full && !drv.pop;
            push_l = drv.push;
            pop_l = drv.pop;
            #5;
        end
    end
endmodule : ftf_dev_model

// >>> verification/ftf_host_test.sv
// Self-checking bench for the fall-through FIFO host controller
`timescale 1ns/1ps
module ftf_host_test;
    import ftf_pkg::*;
    // Short throughput count keeps full and empty waits brief
    localparam int unsigned THRU = 8;
    typedef struct packed {logic [3:0] din; logic [3:0] dout;} ftf_row_s;
    localparam ftf_row_s ROWS [6] = '{8'h00, 8'hff, 8'h55, 8'haa, 8'h33, 8'hcc};
    logic clk, nrst, wr_valid, wr_ready, rd_valid, rd_ready, clear_req, fifo_full, fifo_empty;
    logic [FTF_DATA_W-1:0] wr_data, rd_data, v;
    ftf_drive_s dev_drive;
    ftf_sense_s dev_sense;
    int n_mismatch = 0;
    int n_tests = 0;
    ftf_host #(.THRU_CYC(THRU)) u_ftf_host (.clk(clk), .nrst(nrst), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .rd_data(rd_data), .clear_req(clear_req), .fifo_full(fifo_full),
        .fifo_empty(fifo_empty), .dev_drive(dev_drive), .dev_sense(dev_sense));
    ftf_dev_model u_ftf_dev_model (.drv(dev_drive), .sns(dev_sense));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Hold a word until taken; bounded so a stall shows as a mismatch
    task automatic put(input logic [3:0] d);
        int n = 0;
        @(posedge clk);
        wr_valid <= 1'b1;
        wr_data <= d;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (wr_ready !== 1'b1 && n < 400);
        check(4'(wr_ready), 4'h1);
        @(posedge clk);
        wr_valid <= 1'b0;
    endtask : put
    task automatic get(output logic [3:0] d);
        int n = 0;
        @(posedge clk);
        rd_ready <= 1'b1;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (rd_valid !== 1'b1 && n < 400);
        d = rd_data;
        check(4'(rd_valid), 4'h1);
        @(posedge clk);
        rd_ready <= 1'b0;
    endtask : get
    task automatic settle();
        repeat (3 * THRU) @(posedge clk);
        @(negedge clk);
    endtask : settle
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("BAD %0t watchdog expired", $time);
        final_report();
    end
    initial
    begin
        {nrst, wr_valid, rd_ready, clear_req, wr_data} = '0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check(4'(dev_drive.master_clear_n), 4'h0);
        check(4'(dev_sense.space_available), 4'h1);
        @(posedge clk);
        nrst <= 1'b1;
        foreach (ROWS[i])
        begin
            put(ROWS[i].din);
            get(v);
            check(v, ROWS[i].dout);
        end
        // Consumer stalled: device plus the holding slot take 65 words
        for (int i = 0; i < 65; i++)
            put(4'(i * 7 + 3));
        settle();
        check(4'(fifo_full), 4'h1);
        check(4'(wr_ready), 4'h0);
        for (int i = 0; i < 65; i++)
        begin
            get(v);
            check(v, 4'(i * 7 + 3));
        end
        settle();
        check(4'(fifo_empty), 4'h1);
        check(dev_sense.dout, 4'(64 * 7 + 3));
        check(rd_data, 4'(64 * 7 + 3));
        fork
            for (int i = 0; i < 20; i++)
                put(4'(i + 9));
            for (int j = 0; j < 20; j++)
            begin
                get(v);
                check(v, 4'(j + 9));
            end
        join
        // Clear with words stored, one of them in the holding slot
        for (int i = 0; i < 3; i++)
            put(4'(i));
        settle();
        @(posedge clk);
        clear_req <= 1'b1;
        @(posedge clk);
        clear_req <= 1'b0;
        settle();
        check(4'(rd_valid), 4'h0);
        check(4'(fifo_empty), 4'h1);
        check(4'(dev_sense.space_available), 4'h1);
        put(4'h6);
        get(v);
        check(v, 4'h6);
        final_report();
    end
endmodule : ftf_host_test
